/* File: core/tis_regs.svh */
// timing constants and field widths for the instruction state timer
// assumes inclusion by bare name from the package and the design files
`ifndef TIS_REGS_SVH
`define TIS_REGS_SVH

// ----------------------------------------------------------------
// field widths
// ----------------------------------------------------------------
`define TIS_BASE_W 8
`define TIS_CNT_W 4
`define TIS_TOT_W 10
`define TIS_HLP_W 16

// ----------------------------------------------------------------
// alignment correction for on-chip fetches, in states
// ----------------------------------------------------------------
`define TIS_ALIGN_EVEN 2'h1
`define TIS_ALIGN_ODD 2'h2
`define TIS_ALIGN_NONE 2'h0

// ----------------------------------------------------------------
// reset value and minimum total
// ----------------------------------------------------------------
`define TIS_TOT_RST 10'h000
`define TIS_TOT_MIN 10'h001

`endif

/* File: core/tis_pkg.sv */
// types shared by the instruction state timer modules
// assumes tis_regs.svh is on the include path
`include "tis_regs.svh"

package tis_pkg;

    // ----------------------------------------------------------------
    // controller states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TIS_IDLE = 2'h1,
        TIS_RUN = 2'h2
    } tis_state_e;

    typedef logic [`TIS_TOT_W-1:0] tis_total_t;

endpackage : tis_pkg

/* File: core/tis_cnt_if.sv */
// link between the timing controller and its state down-counter
// assumes both ends run on the same sys_clk
`timescale 1ns/1ns

interface tis_cnt_if;
    import tis_pkg::*;

    logic load;
    tis_total_t load_val;
    logic step;
    tis_total_t count;
    logic zero;

    modport ctrl (output load, output load_val, output step, input count, input zero);
    modport cnt (input load, input load_val, input step, output count, output zero);

endinterface : tis_cnt_if

/* File: core/tis_state_cnt.sv */
// down-counter that spends one count per executed state
// assumes the controller never asserts load and step together
`timescale 1ns/1ns
`include "tis_regs.svh"

module tis_state_cnt
    import tis_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // controller side
    tis_cnt_if.cnt cif
);

    tis_total_t count_r;
    tis_total_t count_nxt;

    // ----------------------------------------------------------------
    // next count
    // ----------------------------------------------------------------
    // stalls at zero so a late step cannot wrap the count
    assign count_nxt = cif.load ? cif.load_val :
                       (cif.step && (count_r != `TIS_TOT_RST)) ? count_r - `TIS_TOT_MIN :
                       count_r;

    // count register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_r <= `TIS_TOT_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    // observed state
    assign cif.count = count_r;
    assign cif.zero = (count_r == `TIS_TOT_RST);

endmodule : tis_state_cnt

/* File: core/tis_timing.sv */
// instruction state timer: computes the state count of one instruction
// from its table figures and access locations, then runs it out
// assumes the decoder supplies base, byte and off-chip counts per request
`timescale 1ns/1ns
`include "tis_regs.svh"

module tis_timing
    import tis_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // instruction request
    input wire logic start,
    input wire logic [`TIS_BASE_W-1:0] base_states,
    input wire logic [`TIS_CNT_W-1:0] opnd_bytes,
    input wire logic [`TIS_CNT_W-1:0] fetch_cnt_j,
    input wire logic [`TIS_CNT_W-1:0] fetch_cnt_k,
    input wire logic fetch_offchip,
    input wire logic odd_addr,
    input wire logic opnd_slow,
    input wire logic opnd_word,
    // external wait
    input wire logic wait_state,
    // status
    output logic busy,
    output logic done,
    output logic [`TIS_TOT_W-1:0] total_states
);

    tis_state_e state_r;
    tis_state_e state_nxt;
    logic done_r;
    tis_total_t total_r;
    tis_cnt_if cif();

    // ----------------------------------------------------------------
    // state count arithmetic
    // ----------------------------------------------------------------
    wire start_ok;
    wire [1:0] align_add;
    wire [`TIS_TOT_W-1:0] opnd_add;
    wire [`TIS_TOT_W-1:0] jk_add;
    wire [`TIS_TOT_W-1:0] total_raw;
    wire [`TIS_TOT_W-1:0] total_load;
    wire last_state;

    // requests while busy are ignored, not queued
    assign start_ok = start && (state_r == TIS_IDLE);
    // alignment only matters when the fetch hits on-chip memory
    assign align_add = fetch_offchip ? `TIS_ALIGN_NONE :
                       odd_addr ? `TIS_ALIGN_ODD : `TIS_ALIGN_EVEN;
    // fast operands cost nothing beyond the base figure
    assign opnd_add = !opnd_slow ? `TIS_TOT_RST :
                      opnd_word ? `TIS_TOT_W'({opnd_bytes, 1'b0}) :
                      `TIS_TOT_W'(opnd_bytes);
    assign jk_add = fetch_offchip ?
                    `TIS_TOT_W'({(5'(fetch_cnt_j) + 5'(fetch_cnt_k)), 1'b0}) :
                    `TIS_TOT_RST;
    assign total_raw = `TIS_TOT_W'(base_states) + `TIS_TOT_W'(align_add)
                     + opnd_add + jk_add;
    // a zero total would never signal done, so run at least one state
    assign total_load = (total_raw == `TIS_TOT_RST) ? `TIS_TOT_MIN : total_raw;

    // ----------------------------------------------------------------
    // counter control
    // ----------------------------------------------------------------
    // a wait state freezes the count for that cycle
    assign cif.load = start_ok;
    assign cif.load_val = total_load;
    assign cif.step = (state_r == TIS_RUN) && !wait_state;
    assign last_state = cif.step && (cif.count == `TIS_TOT_MIN);

    tis_state_cnt tis_state_cnt_inst (
        .sys_clk(sys_clk),
        .reset(reset),
        .cif(cif)
    );

    // next controller state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            TIS_IDLE: begin
                if (start_ok) begin
                    state_nxt = TIS_RUN;
                end
            end
            TIS_RUN: begin
                if (last_state) begin
                    state_nxt = TIS_IDLE;
                end
            end
            default: begin
                state_nxt = TIS_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= TIS_IDLE;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            done_r <= (state_r == TIS_RUN) && last_state;
        end
    end

    // total held for software timing readout until the next start
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            total_r <= `TIS_TOT_RST;
        end else if (start_ok) begin
            total_r <= total_load;
        end
    end

    assign busy = (state_r == TIS_RUN);
    assign done = done_r;
    assign total_states = total_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [`TIS_HLP_W-1:0] run_cyc_r;
    logic [`TIS_HLP_W-1:0] wait_cyc_r;

    // helper counts of run cycles and waits seen during a run
    always_ff @(posedge sys_clk) begin
        if (reset || start_ok) begin
            run_cyc_r <= '0;
            wait_cyc_r <= '0;
        end else if (busy) begin
            run_cyc_r <= run_cyc_r + 16'h0001;
            wait_cyc_r <= wait_cyc_r + `TIS_HLP_W'(wait_state);
        end
    end

    // an all-zero figure still has to run one state before done
    property p_base_only;
        @(posedge sys_clk) disable iff (reset)
        start_ok && fetch_offchip && !opnd_slow && (fetch_cnt_j == 4'h0)
            && (fetch_cnt_k == 4'h0)
        |=> total_r == (($past(base_states) == 8'h00) ? 10'h001 : 10'($past(base_states)));
    endproperty
    a_base_only: assert property (p_base_only) else $error("base count not used alone");

    property p_fast_opnd;
        @(posedge sys_clk) disable iff (reset)
        start_ok && !opnd_slow && !fetch_offchip
        |=> (total_r - 10'($past(base_states))) <= 10'h002;
    endproperty
    a_fast_opnd: assert property (p_fast_opnd) else $error("fast operand lengthened");

    // zero base is left to the minimum-length check above
    property p_jk_offchip;
        @(posedge sys_clk) disable iff (reset)
        start_ok && fetch_offchip && !opnd_slow && (base_states != 8'h00)
        |=> total_r == 10'($past(base_states)) + 10'({5'($past(fetch_cnt_j))
            + 5'($past(fetch_cnt_k)), 1'b0});
    endproperty
    a_jk_offchip: assert property (p_jk_offchip) else $error("off-chip counts wrong");

    property p_align;
        @(posedge sys_clk) disable iff (reset)
        start_ok && !fetch_offchip && !opnd_slow
        |=> total_r == 10'($past(base_states)) + ($past(odd_addr) ? 10'h002 : 10'h001);
    endproperty
    a_align: assert property (p_align) else $error("alignment correction wrong");

    property p_slow_byte;
        @(posedge sys_clk) disable iff (reset)
        start_ok && !fetch_offchip && opnd_slow && !opnd_word
        |=> total_r == 10'($past(base_states)) + ($past(odd_addr) ? 10'h002 : 10'h001)
            + 10'($past(opnd_bytes));
    endproperty
    a_slow_byte: assert property (p_slow_byte) else $error("slow byte total wrong");

    property p_slow_word;
        @(posedge sys_clk) disable iff (reset)
        start_ok && !fetch_offchip && opnd_slow && opnd_word
        |=> total_r == 10'($past(base_states)) + ($past(odd_addr) ? 10'h002 : 10'h001)
            + 10'({$past(opnd_bytes), 1'b0});
    endproperty
    a_slow_word: assert property (p_slow_word) else $error("slow word total wrong");

    property p_off_word;
        @(posedge sys_clk) disable iff (reset)
        start_ok && fetch_offchip && opnd_slow && opnd_word
        |=> total_r == 10'($past(base_states)) + 10'({$past(opnd_bytes), 1'b0})
            + 10'({5'($past(fetch_cnt_j)) + 5'($past(fetch_cnt_k)), 1'b0});
    endproperty
    a_off_word: assert property (p_off_word) else $error("off-chip word total wrong");

    property p_wait_len;
        @(posedge sys_clk) disable iff (reset)
        $rose(done) |-> run_cyc_r == 16'(total_r) + wait_cyc_r;
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("run length not total plus waits");

    property p_off_byte;
        @(posedge sys_clk) disable iff (reset)
        start_ok && fetch_offchip && opnd_slow && !opnd_word
        |=> total_r == 10'($past(base_states)) + 10'($past(opnd_bytes))
            + 10'({5'($past(fetch_cnt_j)) + 5'($past(fetch_cnt_k)), 1'b0});
    endproperty
    a_off_byte: assert property (p_off_byte) else $error("off-chip byte total wrong");

    property p_done_quick;
        @(posedge sys_clk) disable iff (reset)
        start_ok && (total_load == 10'h002) ##1 !wait_state [*2] |=> done;
    endproperty
    a_done_quick: assert property (p_done_quick) else $error("two-state run not done");

    // a running count never empties before the controller leaves the run state
    property p_run_nonzero;
        @(posedge sys_clk) disable iff (reset)
        busy |-> !cif.zero;
    endproperty
    a_run_nonzero: assert property (p_run_nonzero) else $error("count empty while busy");

    c_onchip_odd: cover property (@(posedge sys_clk) disable iff (reset)
        start_ok && !fetch_offchip && odd_addr && opnd_slow);
    c_offchip_word: cover property (@(posedge sys_clk) disable iff (reset)
        start_ok && fetch_offchip && opnd_slow && opnd_word);
    c_wait_run: cover property (@(posedge sys_clk) disable iff (reset)
        busy && wait_state ##[1:20] done);
    c_back_to_back: cover property (@(posedge sys_clk) disable iff (reset)
        done && start_ok);

endmodule : tis_timing

/* File: dv/tis_mem_model.sv */
// memory-side model: stretches a running instruction with external wait states
// assumes busy from the state timer and a wait count set by the bench
`timescale 1ns/1ns

module tis_mem_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // timer side
    input wire logic busy,
    output logic wait_state,
    // bench command: waits to insert in the next instruction
    input wire logic [3:0] wait_cnt
);
    logic [3:0] left_r;

    // count is armed while idle, so every instruction gets its own waits;
    // waits fill the first busy states, so even a one-state run sees them all
    always_ff @(posedge sys_clk) begin
        if (reset || !busy) begin
            left_r <= wait_cnt;
        end else if (left_r != 4'h0) begin
            left_r <= left_r - 4'h1;
        end
    end

    // wait line answers within the busy state that it stretches
    assign wait_state = busy && (left_r != 4'h0);
endmodule : tis_mem_model

/* File: dv/tis_timing_test.sv */
// self-checking bench for the instruction state timer
// assumes the memory model answers with wait states on command
`timescale 1ns/1ns
`include "tis_regs.svh"

module tis_timing_test;
    import tis_pkg::*;

    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic [`TIS_BASE_W-1:0] base_states = 8'h00;
    logic [`TIS_CNT_W-1:0] opnd_bytes = 4'h0;
    logic [`TIS_CNT_W-1:0] fetch_cnt_j = 4'h0;
    logic [`TIS_CNT_W-1:0] fetch_cnt_k = 4'h0;
    logic fetch_offchip = 1'b0;
    logic odd_addr = 1'b0;
    logic opnd_slow = 1'b0;
    logic opnd_word = 1'b0;
    logic [3:0] wait_cnt = 4'h0;
    logic wait_state;
    logic busy;
    logic done;
    logic [`TIS_TOT_W-1:0] total_states;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;

    tis_timing tis_timing_inst (.sys_clk(sys_clk), .reset(reset), .start(start),
        .base_states(base_states), .opnd_bytes(opnd_bytes), .fetch_cnt_j(fetch_cnt_j),
        .fetch_cnt_k(fetch_cnt_k), .fetch_offchip(fetch_offchip), .odd_addr(odd_addr),
        .opnd_slow(opnd_slow), .opnd_word(opnd_word), .wait_state(wait_state),
        .busy(busy), .done(done), .total_states(total_states));

    tis_mem_model tis_mem_model_inst (.sys_clk(sys_clk), .reset(reset), .busy(busy),
        .wait_state(wait_state), .wait_cnt(wait_cnt));

    // ------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------
    always #25 sys_clk = ~sys_clk;

    // a hang in any handshake ends here, well past the longest test
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            $display("wrong value at %0t: timeout", $time);
            results();
        end
    end

    task automatic chk(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : chk

    // reference total, worked out independently of the design
    function automatic int exp_tot(input int b, i, j, k, input bit off, odd, slow, word);
        int t;
        t = b + (off ? 2 * (j + k) : (odd ? 2 : 1));
        if (slow) begin
            t += word ? 2 * i : i;
        end
        return (t == 0) ? 1 : t;
    endfunction : exp_tot

    // present one request; returns on the edge that takes it
    task automatic issue(input int b, i, j, k, input bit off, odd, slow, word, input int w);
        @(posedge sys_clk);
        start <= 1'b1;
        base_states <= 8'(b);
        opnd_bytes <= 4'(i);
        fetch_cnt_j <= 4'(j);
        fetch_cnt_k <= 4'(k);
        fetch_offchip <= off;
        odd_addr <= odd;
        opnd_slow <= slow;
        opnd_word <= word;
        wait_cnt <= 4'(w);
        @(posedge sys_clk);
        start <= 1'b0;
    endtask : issue

    // checks total, busy and the exact state of the done pulse
    task automatic wait_done(input int t, input int w);
        int n;
        @(negedge sys_clk);
        n = 1;
        chk(total_states === 10'(t) && busy === 1'b1, "total or busy");
        while (done !== 1'b1 && n < 800) begin
            @(negedge sys_clk);
            n++;
        end
        chk(n == t + w + 1, "done timing");
        @(negedge sys_clk);
        chk(done === 1'b0 && busy === 1'b0, "done pulse");
    endtask : wait_done

    task automatic run(input int b, i, j, k, input bit off, odd, slow, word, input int w);
        issue(b, i, j, k, off, odd, slow, word, w);
        wait_done(exp_tot(b, i, j, k, off, odd, slow, word), w);
    endtask : run

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_align;
        run(5, 1, 1, 1, 0, 0, 0, 0, 0);
        run(5, 1, 1, 1, 0, 1, 0, 0, 0);
        run(1, 0, 0, 0, 0, 0, 0, 0, 0);
    endtask : t_align

    task automatic t_slow_opnd;
        run(9, 1, 0, 0, 0, 0, 1, 0, 0);
        run(9, 2, 3, 3, 0, 1, 1, 1, 0);
    endtask : t_slow_opnd

    task automatic t_offchip;
        run(5, 1, 1, 1, 1, 1, 0, 0, 0);
        run(5, 2, 1, 1, 1, 0, 1, 1, 0);
        run(6, 3, 2, 0, 1, 1, 1, 0, 0);
        run(7, 0, 0, 0, 1, 0, 0, 0, 0);
    endtask : t_offchip

    // zero sum still yields one state; widest sum must not wrap
    task automatic t_bounds;
        run(0, 0, 0, 0, 1, 0, 0, 0, 0);
        run(255, 15, 15, 15, 1, 1, 1, 1, 0);
    endtask : t_bounds

    task automatic t_waits;
        run(3, 0, 0, 0, 0, 0, 0, 0, 3);
        run(0, 0, 0, 0, 1, 0, 0, 0, 1);
    endtask : t_waits

    // a start while busy is dropped; one in the done state is taken
    task automatic t_overlap;
        issue(4, 0, 0, 0, 0, 0, 0, 0, 0);
        issue(20, 0, 0, 0, 0, 0, 0, 0, 0);
        @(negedge sys_clk);
        chk(total_states === 10'h005, "start taken while busy");
        repeat (2) @(posedge sys_clk);
        issue(7, 0, 0, 0, 0, 0, 0, 0, 0);
        wait_done(8, 0);
    endtask : t_overlap

    task automatic results;
        $display("compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        chk(busy === 1'b0 && done === 1'b0 && total_states === 10'h000, "reset state");
        t_align();
        t_slow_opnd();
        t_offchip();
        t_bounds();
        t_waits();
        t_overlap();
        results();
    end
endmodule : tis_timing_test
